/* File: sensor_sample_fifo_and_irq_pins_tb_top.sv */
`timescale 1ns/1ps
module sensor_sample_fifo_and_irq_pins_tb_top;
  import ssf_pkg::*;
  localparam logic [5:0] ST = SSF_ADDR_EVENT_STATUS;
  localparam logic [5:0] BC = SSF_ADDR_BUFFER_CONTROL;
  localparam logic [5:0] SC = SSF_ADDR_BUFFER_SAMPLE_COUNT;
  logic sys_clk, rst, reg_wr, reg_rd, buf_rd, sample_valid, new_data;
  logic activity_event, inactivity_event, awake_level, h1_en, h2_en;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, buf_rdata, rv, rv1;
  logic [11:0] sample_x, sample_y, sample_z, sample_temp;
  logic irq_pin_one_in, irq_pin_one_out, irq_pin_one_oe_n;
  logic irq_pin_two_in, irq_pin_two_out, irq_pin_two_oe_n;
  logic ext_clock_level, ext_trigger_level;
  logic [15:0] ev;
  int mismatches = 0;
  int tests_run = 0;
  ssf_top #(.DEPTH(8), .AW(3)) DUT (.*);
  ssf_host_pins u_pin_one (.dev_out(irq_pin_one_out),
    .dev_oe_n(irq_pin_one_oe_n), .host_en(h1_en), .level(irq_pin_one_in));
  ssf_host_pins u_pin_two (.dev_out(irq_pin_two_out),
    .dev_oe_n(irq_pin_two_oe_n), .host_en(h2_en), .level(irq_pin_two_in));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd2(input logic [5:0] a, input logic [5:0] b, input bit two);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    rv1 = reg_rdata;
    reg_addr = b;
    reg_rd = two;
    if (two) @(negedge sys_clk);
    reg_rd = 1'b0;
    rv = reg_rdata;
  endtask
  // One entry is always fetched as a whole byte pair.
  task automatic pop;
    @(negedge sys_clk);
    buf_rd = 1'b1;
    @(negedge sys_clk);
    ev[7:0] = buf_rdata;
    @(negedge sys_clk);
    buf_rd = 1'b0;
    ev[15:8] = buf_rdata;
    repeat (2) @(negedge sys_clk);
  endtask
  function automatic logic [11:0] dat(input int t, input int s);
    return 12'(s) + ((t == 0) ? 12'hf00 : (t == 1) ? 12'h010 :
      (t == 2) ? 12'h820 : 12'h030);
  endfunction
  task automatic popchk(input int t, input int s);
    logic [11:0] d;
    d = dat(t, s);
    pop;
    chk(ev, {2'(t), {2{d[11]}}, d});
  endtask
  task automatic put(input int s);
    @(negedge sys_clk);
    sample_valid = 1'b1;
    sample_x = dat(0, s);
    sample_y = dat(1, s);
    sample_z = dat(2, s);
    sample_temp = dat(3, s);
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_stream;
    chk({irq_pin_one_oe_n, irq_pin_two_oe_n}, 2'b11);
    rd2(SC, 6'h3f, 1'b1);
    chk({rv1, rv}, {SSF_RST_SAMPLE_COUNT, 8'h00});
    wr(SC, 8'h04);
    wr(BC, 8'h06);
    put(1);
    put(2);
    rd2(ST, ST, 1'b0);
    chk(rv[3:1], 3'b011);
    for (int i = 0; i < 8; i++) popchk(i % 4, 1 + i / 4);
    rd2(ST, ST, 1'b0);
    chk(rv[3:1], 3'b000);
    pop;
    chk(ev, 16'h0000);
    wr(SC, 8'h00);
    wr(BC, 8'h0a);
    rd2(ST, ST, 1'b0);
    chk(rv[2], 1'b0);
    wr(BC, 8'h02);
    rd2(ST, ST, 1'b0);
    chk(rv[2], 1'b1);
  endtask
  task automatic t_modes;
    wr(BC, 8'h01);
    for (int s = 1; s < 4; s++) put(s);
    rd2(ST, ST, 1'b0);
    chk(rv[3], 1'b1);
    popchk(0, 1);
    put(4);
    for (int i = 1; i < 8; i++) popchk(i % 3, 1 + i / 3);
    popchk(0, 4);
    wr(BC, 8'h02);
    for (int s = 1; s < 4; s++) put(s);
    for (int i = 1; i < 9; i++) popchk(i % 3, 1 + i / 3);
    wr(SC, 8'h03);
    wr(BC, 8'h03);
    put(1);
    put(2);
    @(negedge sys_clk);
    activity_event = 1'b1;
    @(negedge sys_clk);
    activity_event = 1'b0;
    rd2(ST, ST, 1'b0);
    chk(rv[SSF_ST_ACT_BIT], 1'b1);
    for (int s = 3; s < 6; s++) put(s);
    for (int i = 0; i < 8; i++) popchk(i % 3, 2 + i / 3);
    pop;
    chk(ev, 16'h0000);
    wr(BC, 8'h01);
    put(6);
    wr(BC, 8'h00);
    put(5);
    rd2(ST, ST, 1'b0);
    chk({rv[3], rv[1]}, 2'b00);
    wr(BC, 8'h01);
    pop;
    chk(ev, 16'h0000);
  endtask
  task automatic t_irq;
    // Maps are set only after the buffer setup is complete.
    wr(SSF_ADDR_IRQ_MAP_ONE, 8'h02);
    wr(SSF_ADDR_IRQ_MAP_TWO, 8'h82);
    repeat (3) @(negedge sys_clk);
    chk({irq_pin_one_oe_n, irq_pin_one_in, irq_pin_two_oe_n, irq_pin_two_in},
      4'b0001);
    put(6);
    repeat (2) @(negedge sys_clk);
    chk({irq_pin_one_in, irq_pin_two_in}, 2'b10);
    repeat (3) pop;
    repeat (2) @(negedge sys_clk);
    chk({irq_pin_one_in, irq_pin_two_in}, 2'b01);
    wr(SSF_ADDR_IRQ_MAP_ONE, 8'h12);
    @(negedge sys_clk);
    {activity_event, inactivity_event} = 2'b11;
    @(negedge sys_clk);
    {activity_event, inactivity_event} = 2'b00;
    repeat (2) @(negedge sys_clk);
    chk(irq_pin_one_in, 1'b1);
    rd2(ST, ST, 1'b1);
    chk({rv1[5:4], rv[5:4]}, 4'b1100);
    repeat (3) @(negedge sys_clk);
    chk(irq_pin_one_in, 1'b0);
    @(negedge sys_clk);
    new_data = 1'b1;
    @(negedge sys_clk);
    new_data = 1'b0;
    rd2(ST, ST, 1'b0);
    ev[0] = rv[0];
    rd2(SSF_ADDR_DATA_LO, ST, 1'b1);
    chk({ev[0], rv[0]}, 2'b10);
    wr(SSF_ADDR_IRQ_MAP_TWO, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk(irq_pin_two_oe_n, 1'b1);
    wr(SSF_ADDR_POWER_CONTROL, 8'h40);
    wr(SSF_ADDR_FILTER_CONTROL, 8'h08);
    {h1_en, h2_en} = 2'b11;
    repeat (6) @(negedge sys_clk);
    chk({irq_pin_one_oe_n, ext_clock_level, ext_trigger_level},
      3'b111);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, buf_rd, sample_valid, new_data, activity_event} = '0;
    {inactivity_event, awake_level, h1_en, h2_en, reg_addr, reg_wdata} = '0;
    {sample_x, sample_y, sample_z, sample_temp} = '0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_stream;
    t_modes;
    t_irq;
    wrap_up;
  end
  // The tests take a few hundred cycles; this span is far beyond that.
  initial begin
    #1_000_000;
    mismatches++;
    wrap_up;
  end
endmodule // sensor_sample_fifo_and_irq_pins_tb_top

/* File: ssf_host_pins.sv */
`timescale 1ns/1ps
module ssf_host_pins (
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic host_en,
  output logic level
);
  // A bus keeper holds the last level, so an undriven pin never floats.
  initial level = 1'b0;
  always @(dev_out or dev_oe_n or host_en) begin
    if (!dev_oe_n) begin
      level = dev_out;
    end else if (host_en) begin
      level = 1'b1;
    end
  end
endmodule // ssf_host_pins

/* File: ssf_mem.sv */
`timescale 1ns/1ps
module ssf_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // ssf_mem

/* File: ssf_pkg.sv */
package ssf_pkg;
  localparam logic [5:0] SSF_ADDR_DATA_LO = 6'h08;
  localparam logic [5:0] SSF_ADDR_DATA_HI = 6'h0a;
  localparam logic [5:0] SSF_ADDR_DATA2_LO = 6'h0e;
  localparam logic [5:0] SSF_ADDR_DATA2_HI = 6'h15;
  localparam logic [5:0] SSF_ADDR_EVENT_STATUS = 6'h0b;
  localparam logic [5:0] SSF_ADDR_IRQ_MAP_ONE = 6'h2a;
  localparam logic [5:0] SSF_ADDR_IRQ_MAP_TWO = 6'h2b;
  localparam logic [5:0] SSF_ADDR_BUFFER_CONTROL = 6'h28;
  localparam logic [5:0] SSF_ADDR_BUFFER_SAMPLE_COUNT = 6'h29;
  localparam logic [5:0] SSF_ADDR_FILTER_CONTROL = 6'h2c;
  localparam logic [5:0] SSF_ADDR_POWER_CONTROL = 6'h2d;
  localparam logic [7:0] SSF_RST_BUFFER_CONTROL = 8'h00;
  localparam logic [7:0] SSF_RST_SAMPLE_COUNT = 8'h80;
  localparam logic [7:0] SSF_RST_ZERO = 8'h00;
  localparam int SSF_MODE_LSB = 0;
  localparam int SSF_TEMP_EN_BIT = 2;
  localparam int SSF_HIGH_BIT = 3;
  localparam int SSF_ST_READY_BIT = 1;
  localparam int SSF_ST_WATERMARK_BIT = 2;
  localparam int SSF_ST_OVERRUN_BIT = 3;
  localparam int SSF_ST_ACT_BIT = 4;
  localparam int SSF_ST_INACT_BIT = 5;
  localparam int SSF_MAP_LOW_BIT = 7;
  localparam int SSF_EXTERNAL_CLOCK_SELECT_BIT = 6;
  localparam int SSF_EXT_TRIG_BIT = 3;
  localparam int SSF_DEPTH = 512;
  typedef enum logic [1:0] {
    SSF_MODE_OFF = 2'b00,
    SSF_MODE_OLDEST = 2'b01,
    SSF_MODE_STREAM = 2'b10,
    SSF_MODE_TRIGGER = 2'b11
  } ssf_mode_t;
  typedef enum logic [1:0] {
    SSF_TAG_X = 2'b00,
    SSF_TAG_Y = 2'b01,
    SSF_TAG_Z = 2'b10,
    SSF_TAG_TEMP = 2'b11
  } ssf_tag_t;
  typedef enum logic [1:0] {
    SSF_TRG_ARMED = 2'b00,
    SSF_TRG_POST = 2'b01,
    SSF_TRG_DONE = 2'b10
  } ssf_trg_t;
endpackage

/* File: ssf_sync.sv */
`timescale 1ns/1ps
module ssf_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // ssf_sync

/* File: ssf_top.sv */
// Functional notes
// [RULE_01] Mode 00 stores nothing, flushes contents.
// [RULE_02] Mode 01 fills, then drops new samples.
// [RULE_03] Mode 10 drops oldest to admit newest.
// [RULE_04] Stream watermark interrupt at programmed level.
// [RULE_05] Mode 11 keeps pre-event samples, captures once.
// [RULE_06] Storage holds 512 entries.
// [RULE_07] 16-bit entries, low byte read first.
// [RULE_08] Twelve data bits, two sign copies.
// [RULE_09] Top two bits tag X, Y, Z, temperature.
// [RULE_10] Host reads buffer in even byte counts.
// [RULE_11] Reads past empty return zero bytes.
// [RULE_12] Set order X, Y, Z, optional temperature.
// [RULE_13] Partial sets allowed; one read frees one.
// [RULE_14] Pin is OR of mapped sources.
// [RULE_15] Unmapped pin and reset give high-Z.
// [RULE_16] Active high unless map polarity bit set.
// [RULE_17] Status read clears activity and inactivity.
// [RULE_18] Data register reads clear new-data interrupt.
// [RULE_19] Buffer flags clear when condition ends.
// [RULE_20] Watermark bit 2 while count reaches threshold.
// [RULE_21] Overrun bit 3 on replace or no room.
// [RULE_22] Nonempty bit 1 while an entry exists.
// [RULE_23] Power bit 6 makes pin one clock input.
// [RULE_24] Filter bit 3 makes pin two trigger input.
// [RULE_25] Pin in input role signals no interrupt.
// [RULE_26] Host disables interrupts while reconfiguring.
// [RULE_27] Nine-bit count: control high, sample-count low.
`timescale 1ns/1ps
module ssf_top
  import ssf_pkg::*;
#(
  parameter int DEPTH = SSF_DEPTH,
  parameter int AW = 9
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic buf_rd,
  output logic [7:0] buf_rdata,
  input wire logic sample_valid,
  input wire logic [11:0] sample_x,
  input wire logic [11:0] sample_y,
  input wire logic [11:0] sample_z,
  input wire logic [11:0] sample_temp,
  input wire logic new_data,
  input wire logic activity_event,
  input wire logic inactivity_event,
  input wire logic awake_level,
  input wire logic irq_pin_one_in,
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe_n,
  input wire logic irq_pin_two_in,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe_n,
  output logic ext_clock_level,
  output logic ext_trigger_level
);
  logic [7:0] buffer_control_reg;
  logic [7:0] buffer_sample_count_reg;
  logic [7:0] filter_control_reg;
  logic [7:0] power_control_reg;
  logic [7:0] irq_map_one_reg;
  logic [7:0] irq_map_two_reg;
  logic data_ready_reg, act_reg, inact_reg, overrun_reg;
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [1:0] phase_reg;
  logic [2:0] set_left_reg;
  logic [47:0] set_hold_reg;
  logic byte_hi_reg, empty_word_reg;
  logic [AW:0] post_left_reg;
  ssf_trg_t trg_reg;
  logic [15:0] mem_rdata;
  localparam int TW = (AW + 1 > 9) ? AW + 1 : 9;
  logic [TW-1:0] threshold, count_wide;
  logic [15:0] entry;
  logic push, pop, drop, full, flush, stopped;
  ssf_mode_t mode;
  logic sync_one, sync_two;
  logic [7:0] status;

  assign mode = ssf_mode_t'(buffer_control_reg[SSF_MODE_LSB +: 2]);
  // Compared at nine bits or more, so a small buffer never wraps a level.
  assign threshold = TW'({buffer_control_reg[SSF_HIGH_BIT],
                          buffer_sample_count_reg}); // RULE_27
  assign count_wide = TW'(count_reg);
  assign full = (count_reg == (AW+1)'(DEPTH)); // RULE_06
  assign flush = (mode == SSF_MODE_OFF); // RULE_01

  // Register writes; configuration is host-owned state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buffer_control_reg <= SSF_RST_BUFFER_CONTROL;
      buffer_sample_count_reg <= SSF_RST_SAMPLE_COUNT;
      filter_control_reg <= SSF_RST_ZERO;
      power_control_reg <= SSF_RST_ZERO;
      irq_map_one_reg <= SSF_RST_ZERO;
      irq_map_two_reg <= SSF_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        SSF_ADDR_BUFFER_CONTROL: buffer_control_reg <= reg_wdata;
        SSF_ADDR_BUFFER_SAMPLE_COUNT: buffer_sample_count_reg <= reg_wdata;
        SSF_ADDR_FILTER_CONTROL: filter_control_reg <= reg_wdata;
        SSF_ADDR_POWER_CONTROL: power_control_reg <= reg_wdata;
        SSF_ADDR_IRQ_MAP_ONE: irq_map_one_reg <= reg_wdata;
        SSF_ADDR_IRQ_MAP_TWO: irq_map_two_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Set sequencer: one entry per cycle in fixed order.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= SSF_TAG_X;
      set_left_reg <= 3'h0;
      set_hold_reg <= 48'h0000_0000_0000;
    end else if (sample_valid && set_left_reg == 3'h0) begin
      phase_reg <= SSF_TAG_X;
      set_left_reg <= buffer_control_reg[SSF_TEMP_EN_BIT] ? 3'h4 : 3'h3;
      set_hold_reg <= {sample_temp, sample_z, sample_y, sample_x};
    end else if (set_left_reg != 3'h0) begin
      phase_reg <= phase_reg + 2'h1; // RULE_12
      set_left_reg <= set_left_reg - 3'h1;
    end
  end

  always_comb begin
    case (phase_reg)
      SSF_TAG_X: entry[11:0] = set_hold_reg[11:0];
      SSF_TAG_Y: entry[11:0] = set_hold_reg[23:12];
      SSF_TAG_Z: entry[11:0] = set_hold_reg[35:24];
      default: entry[11:0] = set_hold_reg[47:36];
    endcase
    entry[13:12] = {2{entry[11]}}; // RULE_08
    entry[15:14] = phase_reg; // RULE_09
  end

  // Pre-trigger: stream-like until activity, then fill the rest once.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trg_reg <= SSF_TRG_ARMED;
      post_left_reg <= '0;
    end else if (mode != SSF_MODE_TRIGGER) begin
      trg_reg <= SSF_TRG_ARMED;
    end else begin
      case (trg_reg)
        SSF_TRG_ARMED: if (activity_event) begin
          trg_reg <= SSF_TRG_POST; // RULE_05
          post_left_reg <= (threshold >= TW'(DEPTH)) ? '0 :
                           (AW+1)'(TW'(DEPTH) - threshold);
        end
        SSF_TRG_POST: if (push) begin
          post_left_reg <= post_left_reg - 1'b1;
          if (post_left_reg == (AW+1)'(1)) begin
            trg_reg <= SSF_TRG_DONE;
          end
        end
        SSF_TRG_DONE: ;
        default: trg_reg <= SSF_TRG_ARMED;
      endcase
    end
  end

  assign stopped = (mode == SSF_MODE_TRIGGER) &&
                   (trg_reg == SSF_TRG_DONE || post_left_reg == '0 &&
                    trg_reg == SSF_TRG_POST);
  // Before the event, the trigger mode keeps only the newest pre-count.
  always_comb begin
    push = 1'b0;
    drop = 1'b0;
    if (set_left_reg != 3'h0 && !flush && !stopped) begin
      case (mode)
        SSF_MODE_OLDEST: push = !full; // RULE_02 RULE_13
        SSF_MODE_STREAM: begin
          push = 1'b1;
          drop = full; // RULE_03
        end
        SSF_MODE_TRIGGER: begin
          // A zero pre-count keeps nothing before the event.
          push = (trg_reg != SSF_TRG_ARMED) || (threshold != '0);
          drop = push && (full || (trg_reg == SSF_TRG_ARMED &&
                                   count_wide >= threshold));
        end
        default: push = 1'b0;
      endcase
    end
  end

  assign pop = buf_rd && byte_hi_reg && !empty_word_reg; // RULE_13

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0; // RULE_01
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if ((drop || pop) && count_reg != '0) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push && !drop)
                 - (AW+1)'(pop && !(push && drop));
    end
  end

  ssf_mem #(.WIDTH(16), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(push),
    .wr_addr(wr_ptr_reg),
    .wr_data(entry),
    .rd_addr(rd_ptr_reg),
    .rd_data(mem_rdata)
  );

  // Byte sequencer: low byte then high byte; empty gives zeros.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_hi_reg <= 1'b0;
      empty_word_reg <= 1'b0;
      buf_rdata <= 8'h00;
    end else if (buf_rd) begin
      byte_hi_reg <= !byte_hi_reg; // RULE_10
      if (!byte_hi_reg) begin
        empty_word_reg <= (count_reg == '0);
        buf_rdata <= (count_reg == '0) ? 8'h00 : mem_rdata[7:0]; // RULE_07
      end else begin
        buf_rdata <= empty_word_reg ? 8'h00 : mem_rdata[15:8]; // RULE_11
      end
    end
  end

  // Flags: hardware set wins over a read clear in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_reg <= 1'b0;
      inact_reg <= 1'b0;
      data_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      act_reg <= activity_event ||
                 (act_reg && !(reg_rd && reg_addr == SSF_ADDR_EVENT_STATUS));
      inact_reg <= inactivity_event ||
                   (inact_reg &&
                    !(reg_rd && reg_addr == SSF_ADDR_EVENT_STATUS)); // RULE_17
      data_ready_reg <= new_data ||
                        (data_ready_reg && !(reg_rd &&
                        ((reg_addr >= SSF_ADDR_DATA_LO &&
                          reg_addr <= SSF_ADDR_DATA_HI) ||
                         (reg_addr >= SSF_ADDR_DATA2_LO &&
                          reg_addr <= SSF_ADDR_DATA2_HI)))); // RULE_18
      if (flush) begin
        overrun_reg <= 1'b0;
      end else if ((push && drop) || (set_left_reg != 3'h0 &&
                   mode == SSF_MODE_OLDEST && full)) begin
        overrun_reg <= 1'b1; // RULE_21
      end else if (pop) begin
        overrun_reg <= 1'b0; // RULE_19
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[0] = data_ready_reg;
    status[SSF_ST_READY_BIT] = (count_reg != '0); // RULE_22
    status[SSF_ST_WATERMARK_BIT] = (count_wide >= threshold); // RULE_20 RULE_04
    status[SSF_ST_OVERRUN_BIT] = overrun_reg;
    status[SSF_ST_ACT_BIT] = act_reg;
    status[SSF_ST_INACT_BIT] = inact_reg;
    status[6] = awake_level;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        SSF_ADDR_EVENT_STATUS: reg_rdata <= status;
        SSF_ADDR_BUFFER_CONTROL: reg_rdata <= buffer_control_reg;
        SSF_ADDR_BUFFER_SAMPLE_COUNT: reg_rdata <= buffer_sample_count_reg;
        SSF_ADDR_FILTER_CONTROL: reg_rdata <= filter_control_reg;
        SSF_ADDR_POWER_CONTROL: reg_rdata <= power_control_reg;
        SSF_ADDR_IRQ_MAP_ONE: reg_rdata <= irq_map_one_reg;
        SSF_ADDR_IRQ_MAP_TWO: reg_rdata <= irq_map_two_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ssf_sync u_sync_one (
    .sys_clk(sys_clk), .rst(rst), .din(irq_pin_one_in), .dout(sync_one)
  );
  ssf_sync u_sync_two (
    .sys_clk(sys_clk), .rst(rst), .din(irq_pin_two_in), .dout(sync_two)
  );

  // Pin drivers; an input role releases the pin so the host may drive it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_pin_one_out <= 1'b0;
      irq_pin_one_oe_n <= 1'b1; // RULE_15
      irq_pin_two_out <= 1'b0;
      irq_pin_two_oe_n <= 1'b1;
      ext_clock_level <= 1'b0;
      ext_trigger_level <= 1'b0;
    end else begin
      irq_pin_one_out <= (|(status[6:0] & irq_map_one_reg[6:0])) ^
                         irq_map_one_reg[SSF_MAP_LOW_BIT]; // RULE_14 RULE_16
      irq_pin_one_oe_n <= !(|irq_map_one_reg[6:0]) ||
                          power_control_reg[SSF_EXTERNAL_CLOCK_SELECT_BIT]; // RULE_23 RULE_25
      irq_pin_two_out <= (|(status[6:0] & irq_map_two_reg[6:0])) ^
                         irq_map_two_reg[SSF_MAP_LOW_BIT];
      irq_pin_two_oe_n <= !(|irq_map_two_reg[6:0]) ||
                          filter_control_reg[SSF_EXT_TRIG_BIT]; // RULE_24
      ext_clock_level <= sync_one && power_control_reg[SSF_EXTERNAL_CLOCK_SELECT_BIT];
      ext_trigger_level <= sync_two && filter_control_reg[SSF_EXT_TRIG_BIT];
    end
  end
endmodule // ssf_top

/* File: ssf_top_props.sv */
`timescale 1ns/1ps
module ssf_top_props
  import ssf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic buf_rd,
  input wire logic [7:0] buf_rdata,
  input wire logic new_data,
  input wire logic activity_event,
  input wire logic inactivity_event,
  input wire logic irq_pin_one_oe_n,
  input wire logic irq_pin_two_oe_n,
  input wire logic ext_clock_level,
  input wire logic ext_trigger_level
);
  logic st_rd;
  logic quiet;
  assign st_rd = reg_rd && reg_addr == SSF_ADDR_EVENT_STATUS;
  assign quiet = !activity_event && !inactivity_event;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> irq_pin_one_oe_n
    && irq_pin_two_oe_n && reg_rdata == 8'h00 && buf_rdata == 8'h00)
    else $error("Pins or read data not idle after reset.");
  a_status_clear: assert property ((st_rd && quiet) ##1
    (st_rd && quiet) |=> reg_rdata[5:4] == 2'b00)
    else $error("Status read left motion flags set.");
  a_data_clear: assert property ((reg_rd && !new_data &&
    reg_addr == SSF_ADDR_DATA_LO) ##1 (st_rd && !new_data) |=> !reg_rdata[0])
    else $error("Data read left new-data flag set.");
  a_act_shown: assert property (activity_event ##1 !st_rd ##1 st_rd |=>
    reg_rdata[SSF_ST_ACT_BIT]) else $error("Activity flag missing.");
  a_byte_held: assert property (!buf_rd |=> $stable(buf_rdata))
    else $error("Buffer byte changed without a read.");
  a_clk_role: assert property (ext_clock_level |-> irq_pin_one_oe_n)
    else $error("Pin one driven in clock role.");
  a_trig_role: assert property (ext_trigger_level |-> irq_pin_two_oe_n)
    else $error("Pin two driven in trigger role.");
  a_flush_flags: assert property ((reg_wr && reg_wdata[1:0] == 2'b00 &&
    reg_addr == SSF_ADDR_BUFFER_CONTROL) ##[3:20] st_rd |=>
    !reg_rdata[3] && !reg_rdata[1]) else $error("Flags set after disable.");
  c_two_status: cover property (st_rd ##1 st_rd);
  c_pair_read: cover property (buf_rd ##1 buf_rd);
  c_clock_role: cover property ($rose(ext_clock_level));
endmodule // ssf_top_props
bind ssf_top ssf_top_props u_props (.*);
